// [clp_pkg.sv]
// Shared constants for the per-channel loop limit and period register bank
package clp_pkg;
  // Frame layout
  localparam int FRM_RW_BIT = 31;
  localparam int FRM_CODE_MSB = 30;
  localparam int FRM_CODE_LSB = 27;
  localparam int FRM_CH_MSB = 25;
  localparam int FRM_CH_LSB = 24;
  localparam int CODE_W = 4;
  localparam int CH_W = 2;
  localparam int NUM_CH = 2;

  // Register codes carried in the frame
  localparam logic [3:0] CODE_INTEGRATOR_BOUNDS = 4'h4;
  localparam logic [3:0] CODE_SWITCHING_PERIOD_CONTROL = 4'h5;
  localparam logic [3:0] CODE_TURNOFF_THRESHOLD_OPEN_LOAD = 4'h6;

  // Channel selector codes
  localparam logic [1:0] CH_FIRST_OUTPUT_CHANNEL = 2'h1;
  localparam logic [1:0] CH_SECOND_OUTPUT_CHANNEL = 2'h2;

  // integrator_bounds fields
  localparam int BOUND_W = 12;
  localparam int HI_MSB = 23;
  localparam int HI_LSB = 12;
  localparam int LO_MSB = 11;
  localparam int LO_LSB = 0;
  localparam logic [11:0] HI_RST = 12'h7FF;
  localparam logic [11:0] LO_RST = 12'h7FF;
  localparam int BOUND_SCALE_SHIFT = 5;

  // switching_period_control fields
  localparam int KI_W = 3;
  localparam int KI_MSB = 22;
  localparam int KI_LSB = 20;
  localparam logic [2:0] KI_RST = 3'h2;
  localparam logic [2:0] KI_MAX = 3'h6;
  localparam logic [2:0] KI_SAT_IN = 3'h7;
  localparam int PER_W = 12;
  localparam int PER_MSB = 11;
  localparam int PER_LSB = 0;
  localparam logic [11:0] PER_RST = 12'h000;

  // turnoff_threshold_open_load fields
  localparam int THR_W = 16;
  localparam int THR_MSB = 21;
  localparam int THR_LSB = 6;
  localparam logic [15:0] THR_RST = 16'h0000;
  localparam int OL_W = 6;
  localparam int OL_MSB = 5;
  localparam int OL_LSB = 0;
  localparam logic [5:0] OL_RST = 6'h00;

  // Timing
  localparam int SYSTEM_CLOCK_FREQUENCY = 20_000_000;
  localparam int PERIOD_TICK_CLKS = 16;
  localparam int PRESCALE_W = $clog2(PERIOD_TICK_CLKS);
  localparam int INTEG_W = 19;
endpackage

// [clp_chan_cfg.sv]
// Writable configuration fields of one output channel
module clp_chan_cfg
  import clp_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic wr_en_i,
  input wire logic [CODE_W-1:0] wr_code_i,
  input wire logic [31:0] wr_data_i,
  output logic [BOUND_W-1:0] high_bound_o,
  output logic [BOUND_W-1:0] low_bound_o,
  output logic [KI_W-1:0] integral_gain_exponent_o,
  output logic [PER_W-1:0] target_period_o,
  output logic [OL_W-1:0] open_load_thresh_o
);
  logic [BOUND_W-1:0] high_reg, high_next;
  logic [BOUND_W-1:0] low_reg, low_next;
  logic [KI_W-1:0] ki_reg, ki_next;
  logic [PER_W-1:0] per_reg, per_next;
  logic [OL_W-1:0] ol_reg, ol_next;
  logic [KI_W-1:0] ki_wr;

  always_comb begin
    high_next = high_reg;
    low_next = low_reg;
    ki_next = ki_reg;
    per_next = per_reg;
    ol_next = ol_reg;
    ki_wr = wr_data_i[KI_MSB:KI_LSB];
    if (wr_en_i) begin
      case (wr_code_i)
        CODE_INTEGRATOR_BOUNDS: begin
          high_next = wr_data_i[HI_MSB:HI_LSB]; // [R3]
          low_next = wr_data_i[LO_MSB:LO_LSB]; // [R5]
        end
        CODE_SWITCHING_PERIOD_CONTROL: begin
          ki_next = (ki_wr == KI_SAT_IN) ? KI_MAX : ki_wr; // [R7] [R8]
          per_next = wr_data_i[PER_MSB:PER_LSB]; // [R10]
        end
        CODE_TURNOFF_THRESHOLD_OPEN_LOAD: begin
          // Threshold bits in the frame are dropped: that field is read-only
          ol_next = wr_data_i[OL_MSB:OL_LSB]; // [R13] [R11]
        end
        default: begin
          high_next = high_reg;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      high_reg <= HI_RST; // [R3]
      low_reg <= LO_RST; // [R5]
      ki_reg <= KI_RST; // [R9]
      per_reg <= PER_RST;
      ol_reg <= OL_RST; // [R13]
    end else begin
      high_reg <= high_next;
      low_reg <= low_next;
      ki_reg <= ki_next;
      per_reg <= per_next;
      ol_reg <= ol_next;
    end
  end

  assign high_bound_o = high_reg;
  assign low_bound_o = low_reg;
  assign integral_gain_exponent_o = ki_reg;
  assign target_period_o = per_reg;
  assign open_load_thresh_o = ol_reg;
endmodule // clp_chan_cfg

// [clp_period_ctrl.sv]
// Period controller of one channel: measures the switching period, integrates the error
module clp_period_ctrl
  import clp_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic cycle_start_i,
  input wire logic [PER_W-1:0] target_period_i,
  input wire logic [KI_W-1:0] integral_gain_exponent_i,
  input wire logic [BOUND_W-1:0] high_bound_i,
  input wire logic [BOUND_W-1:0] low_bound_i,
  output logic [THR_W-1:0] threshold_o,
  output logic [PER_W-1:0] measured_period_o
);
  logic [PRESCALE_W-1:0] pre_reg, pre_next;
  logic [PER_W-1:0] cnt_reg, cnt_next;
  logic [PER_W-1:0] meas_reg, meas_next;
  logic signed [INTEG_W-1:0] integ_reg, integ_next;
  logic [THR_W-1:0] thr_reg, thr_next;
  logic tick;
  logic signed [INTEG_W-1:0] err;
  logic signed [INTEG_W-1:0] upper_eff;
  logic signed [INTEG_W-1:0] lower_eff;
  logic signed [INTEG_W-1:0] sum;

  always_comb begin
    tick = (pre_reg == PRESCALE_W'(PERIOD_TICK_CLKS - 1)); // [R10]
    pre_next = tick ? '0 : pre_reg + 1'b1;
    cnt_next = cnt_reg;
    if (cycle_start_i) begin
      cnt_next = '0;
    end else if (tick && cnt_reg != '1) begin
      cnt_next = cnt_reg + 1'b1;
    end
    upper_eff = INTEG_W'({high_bound_i, {BOUND_SCALE_SHIFT{1'b0}}}); // [R4]
    lower_eff = -INTEG_W'({low_bound_i, {BOUND_SCALE_SHIFT{1'b0}}}); // [R6]
    // A longer period than wanted raises the turn-off level, a shorter one lowers it
    err = INTEG_W'(cnt_reg) - INTEG_W'(target_period_i);
    sum = integ_reg + (err >>> integral_gain_exponent_i); // [R7]
    meas_next = meas_reg;
    integ_next = integ_reg;
    if (cycle_start_i) begin
      meas_next = cnt_reg;
      if (sum > upper_eff) begin
        integ_next = upper_eff; // [R4]
      end else if (sum < lower_eff) begin
        integ_next = lower_eff; // [R6]
      end else begin
        integ_next = sum;
      end
    end
    if (integ_reg < 0) begin
      thr_next = '0;
    end else if (integ_reg > INTEG_W'(THR_W'('1))) begin
      thr_next = '1;
    end else begin
      thr_next = integ_reg[THR_W-1:0];
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      pre_reg <= '0;
      cnt_reg <= '0;
      meas_reg <= '0;
      integ_reg <= '0;
      thr_reg <= THR_RST; // [R12]
    end else begin
      pre_reg <= pre_next;
      cnt_reg <= cnt_next;
      meas_reg <= meas_next;
      integ_reg <= integ_next;
      thr_reg <= thr_next; // [R12]
    end
  end

  assign threshold_o = thr_reg;
  assign measured_period_o = meas_reg;
endmodule // clp_period_ctrl

// [clp_regs.sv]
// Register bank for loop limits, period control and turn-off threshold of two channels
// What this block does
// [R1] Top frame bit: 1 write; reads return 0
// [R2] Bits 25:24 select channel: 01 first, 10 second
// [R3] High integrator bound, bits 23:12, reset 07FF
// [R4] Upper bound applied as field times 32
// [R5] Low integrator bound, bits 11:0, reset 07FF
// [R6] Lower bound applied as field times -32
// [R7] Gain exponent bits 22:20; gain two^-exponent
// [R8] Writing seven stores six instead
// [R9] Gain exponent resets to 010
// [R10] Period bits 11:0, sixteen clocks per count
// [R11] Read-only 16-bit turn-off threshold, bits 21:6
// [R12] Controller updates threshold; resets to zero
// [R13] Open-load-on threshold bits 5:0, reset zero
// [R14] Zero threshold disables open-load-on detection
// [R15] Writes with selector 00 or 11 ignored
module clp_regs
  import clp_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic frame_valid_i,
  input wire logic [31:0] frame_data_i,
  input wire logic [NUM_CH-1:0] cycle_start_i,
  output logic reply_valid_o,
  output logic [31:0] reply_data_o,
  output logic [NUM_CH-1:0][THR_W-1:0] turnoff_threshold_o,
  output logic [NUM_CH-1:0][PER_W-1:0] measured_period_o,
  output logic [NUM_CH-1:0][OL_W-1:0] open_load_thresh_o,
  output logic [NUM_CH-1:0] open_load_detect_en_o
);
  // Channel code to one-hot channel select; 00 and 11 select nothing
  function automatic logic [NUM_CH-1:0] chan_select(input logic [CH_W-1:0] ch);
    logic [NUM_CH-1:0] sel;
    sel = '0;
    case (ch)
      CH_FIRST_OUTPUT_CHANNEL: sel = 2'h1; // [R2]
      CH_SECOND_OUTPUT_CHANNEL: sel = 2'h2; // [R2]
      default: sel = '0; // [R15]
    endcase
    return sel;
  endfunction

  logic [CODE_W-1:0] code;
  logic [CH_W-1:0] ch;
  logic is_write;
  logic [NUM_CH-1:0] sel;
  logic [NUM_CH-1:0] wr_en;
  logic [NUM_CH-1:0][BOUND_W-1:0] high_bound;
  logic [NUM_CH-1:0][BOUND_W-1:0] low_bound;
  logic [NUM_CH-1:0][KI_W-1:0] ki_exp;
  logic [NUM_CH-1:0][PER_W-1:0] target_period;
  logic [NUM_CH-1:0][OL_W-1:0] ol_thresh;
  logic [NUM_CH-1:0][THR_W-1:0] threshold;
  logic reply_valid_reg, reply_valid_next;
  logic [31:0] reply_reg, reply_next;
  logic [NUM_CH-1:0] ol_en_reg, ol_en_next;
  logic [31:0] field_word;

  assign code = frame_data_i[FRM_CODE_MSB:FRM_CODE_LSB];
  assign ch = frame_data_i[FRM_CH_MSB:FRM_CH_LSB];
  assign is_write = frame_data_i[FRM_RW_BIT]; // [R1]
  assign sel = chan_select(ch);
  assign wr_en = (frame_valid_i && is_write) ? sel : '0; // [R15]

  genvar gi;
  generate
    for (gi = 0; gi < NUM_CH; gi++) begin : g_chan
      clp_chan_cfg u_cfg (
        .core_clk_i(core_clk_i),
        .reset_i(reset_i),
        .wr_en_i(wr_en[gi]),
        .wr_code_i(code),
        .wr_data_i(frame_data_i),
        .high_bound_o(high_bound[gi]),
        .low_bound_o(low_bound[gi]),
        .integral_gain_exponent_o(ki_exp[gi]),
        .target_period_o(target_period[gi]),
        .open_load_thresh_o(ol_thresh[gi])
      );
      clp_period_ctrl u_ctrl (
        .core_clk_i(core_clk_i),
        .reset_i(reset_i),
        .cycle_start_i(cycle_start_i[gi]),
        .target_period_i(target_period[gi]),
        .integral_gain_exponent_i(ki_exp[gi]),
        .high_bound_i(high_bound[gi]),
        .low_bound_i(low_bound[gi]),
        .threshold_o(threshold[gi]),
        .measured_period_o(measured_period_o[gi])
      );
    end
  endgenerate

  // Read-back fields of the addressed register, from pre-write contents
  always_comb begin
    int idx;
    idx = 0;
    field_word = '0;
    if (sel == 2'h2) begin
      idx = 1;
    end
    if (sel != '0) begin
      case (code)
        CODE_INTEGRATOR_BOUNDS: begin
          field_word[HI_MSB:HI_LSB] = high_bound[idx]; // [R3]
          field_word[LO_MSB:LO_LSB] = low_bound[idx]; // [R5]
        end
        CODE_SWITCHING_PERIOD_CONTROL: begin
          field_word[KI_MSB:KI_LSB] = ki_exp[idx]; // [R7]
          field_word[PER_MSB:PER_LSB] = target_period[idx]; // [R10]
        end
        CODE_TURNOFF_THRESHOLD_OPEN_LOAD: begin
          field_word[THR_MSB:THR_LSB] = threshold[idx]; // [R11]
          field_word[OL_MSB:OL_LSB] = ol_thresh[idx]; // [R13]
        end
        default: begin
          field_word = '0;
        end
      endcase
    end
  end

  always_comb begin
    reply_valid_next = frame_valid_i;
    reply_next = reply_reg;
    if (frame_valid_i) begin
      reply_next = field_word;
      reply_next[FRM_RW_BIT] = 1'b0; // [R1]
      reply_next[FRM_CODE_MSB:FRM_CODE_LSB] = code;
      reply_next[FRM_CH_MSB:FRM_CH_LSB] = ch; // [R2]
    end
    for (int i = 0; i < NUM_CH; i++) begin
      ol_en_next[i] = (ol_thresh[i] != '0); // [R14]
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      reply_valid_reg <= 1'b0;
      reply_reg <= '0;
      ol_en_reg <= '0;
    end else begin
      reply_valid_reg <= reply_valid_next;
      reply_reg <= reply_next;
      ol_en_reg <= ol_en_next; // [R14]
    end
  end

  assign reply_valid_o = reply_valid_reg;
  assign reply_data_o = reply_reg;
  assign turnoff_threshold_o = threshold;
  assign open_load_thresh_o = ol_thresh;
  assign open_load_detect_en_o = ol_en_reg;
endmodule // clp_regs

// [clp_regs_assertions.sv]
// Port checks for the loop limit and period register bank
module clp_regs_assertions
  import clp_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic frame_valid_i,
  input wire logic [31:0] frame_data_i,
  input wire logic [NUM_CH-1:0] cycle_start_i,
  input wire logic reply_valid_o,
  input wire logic [31:0] reply_data_o,
  input wire logic [NUM_CH-1:0][THR_W-1:0] turnoff_threshold_o,
  input wire logic [NUM_CH-1:0][PER_W-1:0] measured_period_o,
  input wire logic [NUM_CH-1:0][OL_W-1:0] open_load_thresh_o,
  input wire logic [NUM_CH-1:0] open_load_detect_en_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  // Write of the open-load field on the first channel
  sequence ol_wr1;
    frame_valid_i && frame_data_i[31] && frame_data_i[30:24] == 7'h31;
  endsequence
  a_reply_follows: assert property (frame_valid_i |=> reply_valid_o)
    else $error("frame not answered");
  a_reply_single: assert property (!frame_valid_i |=> !reply_valid_o)
    else $error("reply without frame");
  a_rw_bit_low: assert property (reply_valid_o |-> !reply_data_o[31])
    else $error("reply top bit set");
  a_header_echo: assert property (frame_valid_i |=> reply_data_o[30:24] ==
    {$past(frame_data_i[30:27]), 1'b0, $past(frame_data_i[25:24])})
    else $error("reply header wrong");
  a_reset_quiet: assert property ($fell(reset_i) |-> !reply_valid_o &&
    turnoff_threshold_o == '0 && open_load_thresh_o == '0)
    else $error("outputs not cleared by reset");
  a_ol_store: assert property (ol_wr1 |-> ##2
    open_load_thresh_o[0] == $past(frame_data_i[5:0], 2))
    else $error("open load field not stored");
  a_detect_follows: assert property (1'b1 |=> open_load_detect_en_o ==
    {|$past(open_load_thresh_o[1]), |$past(open_load_thresh_o[0])})
    else $error("detect enable wrong");
  a_gain_capped: assert property (reply_valid_o && reply_data_o[30:27] == 4'h5 |->
    reply_data_o[22:20] != 3'h7)
    else $error("gain exponent above six");
  a_thr_cause: assert property ($changed(turnoff_threshold_o) |->
    $past(|cycle_start_i, 2))
    else $error("threshold moved without cycle start");
endmodule // clp_regs_assertions

// [clp_host_model.sv]
// Host model that issues register frames to the bank
module clp_host_model
  import clp_pkg::*;
(
  input wire logic core_clk_i,
  output logic frame_valid_o,
  output logic [31:0] frame_data_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    frame_valid_o = 1'b0;
    frame_data_o = 32'h0;
  end
  task automatic send(input logic wr, input logic [3:0] c, input logic [1:0] ch,
                      input logic [23:0] f);
    @(posedge core_clk_i);
    frame_valid_o <= 1'b1;
    frame_data_o <= {wr, c, 1'b0, ch, f};
  endtask
  // Idle data is inverted so a stale frame never looks valid
  task automatic idle();
    @(posedge core_clk_i);
    frame_valid_o <= 1'b0;
    frame_data_o <= ~frame_data_o;
  endtask
endmodule // clp_host_model

// [clp_regs_tb.sv]
// Self-checking bench for the loop limit and period register bank
module clp_regs_tb
  import clp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic fv;
  logic [31:0] fd;
  logic [NUM_CH-1:0] cs = '0;
  logic rv;
  logic [31:0] rd;
  logic [NUM_CH-1:0][THR_W-1:0] thr;
  logic [NUM_CH-1:0][PER_W-1:0] mp;
  logic [NUM_CH-1:0][OL_W-1:0] ol;
  logic [NUM_CH-1:0] den;
  logic [31:0] expq[$];
  int err_count = 0;
  int num_checks = 0;
  logic [11:0] m_hi[4], m_lo[4], m_per[4];
  logic [2:0] m_ki[4];
  logic [5:0] m_ol[4];
  logic [15:0] m_thr[4];
  always #25 core_clk_i = ~core_clk_i;
  clp_host_model clp_host_model_inst(.core_clk_i(core_clk_i), .frame_valid_o(fv),
    .frame_data_o(fd));
  clp_regs clp_regs_inst(.core_clk_i(core_clk_i), .reset_i(reset_i), .frame_valid_i(fv),
    .frame_data_i(fd), .cycle_start_i(cs), .reply_valid_o(rv), .reply_data_o(rd),
    .turnoff_threshold_o(thr), .measured_period_o(mp), .open_load_thresh_o(ol),
    .open_load_detect_en_o(den));
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic give_verdict();
    if (err_count == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Expected reply holds the contents from before a write in the same frame
  task automatic xfer(input logic wr, input logic [3:0] c, input logic [1:0] ch,
                      input logic [23:0] f);
    logic [23:0] e;
    e = 24'h0;
    if (ch == CH_FIRST_OUTPUT_CHANNEL || ch == CH_SECOND_OUTPUT_CHANNEL) begin
      if (c == CODE_INTEGRATOR_BOUNDS) e = {m_hi[ch], m_lo[ch]};
      if (c == CODE_SWITCHING_PERIOD_CONTROL) e = {1'b0, m_ki[ch], 8'h00, m_per[ch]};
      if (c == CODE_TURNOFF_THRESHOLD_OPEN_LOAD) e = {2'b00, m_thr[ch], m_ol[ch]};
      if (wr && c == CODE_INTEGRATOR_BOUNDS) {m_hi[ch], m_lo[ch]} = f;
      if (wr && c == CODE_SWITCHING_PERIOD_CONTROL) begin
        m_ki[ch] = (f[22:20] == KI_SAT_IN) ? KI_MAX : f[22:20];
        m_per[ch] = f[11:0];
      end
      if (wr && c == CODE_TURNOFF_THRESHOLD_OPEN_LOAD) m_ol[ch] = f[5:0];
    end
    expq.push_back({1'b0, c, 1'b0, ch, e});
    clp_host_model_inst.send(wr, c, ch, f);
  endtask
  always @(posedge core_clk_i) begin
    if (rv === 1'b1) begin
      if (expq.size() == 0) check("extra reply", 32'h1, 32'h0);
      else check("reply", rd, expq.pop_front());
    end
  end
  initial begin
    int i;
    int c;
    logic [23:0] r;
    logic [1:0] ch;
    int k;
    int g;
    logic [31:0] acc;
    r = 24'($urandom(64));
    for (i = 0; i < 4; i++) begin
      m_hi[i] = HI_RST;
      m_lo[i] = LO_RST;
      m_ki[i] = KI_RST;
      m_per[i] = PER_RST;
      m_ol[i] = OL_RST;
      m_thr[i] = THR_RST;
    end
    repeat (12) @(posedge core_clk_i);
    reset_i <= 1'b0;
    for (i = 0; i < 8; i++) begin
      ch = 2'(1 + i % 2);
      for (c = 4; c < 7; c++) xfer(1'b0, 4'(c), ch, 24'h0);
      r = 24'($urandom());
      xfer(1'b1, CODE_INTEGRATOR_BOUNDS, ch, r);
      xfer(1'b1, CODE_SWITCHING_PERIOD_CONTROL, ch, {1'b0, 3'(i), 8'h00, r[11:0]});
      xfer(1'b1, CODE_TURNOFF_THRESHOLD_OPEN_LOAD, ch, ~r);
      xfer(1'b1, 4'(4 + i % 3), 2'(3 * (i % 2)), r);
    end
    for (i = 1; i < 3; i++) begin
      for (c = 4; c < 7; c++) xfer(1'b0, 4'(c), 2'(i), 24'h0);
    end
    xfer(1'b1, CODE_TURNOFF_THRESHOLD_OPEN_LOAD, CH_FIRST_OUTPUT_CHANNEL, 24'h0);
    xfer(1'b1, CODE_TURNOFF_THRESHOLD_OPEN_LOAD, CH_SECOND_OUTPUT_CHANNEL, 24'h3F);
    clp_host_model_inst.idle();
    repeat (3) @(posedge core_clk_i);
    for (i = 1; i < 3; i++) begin
      check("open load", 32'(ol[i-1]), 32'(m_ol[i]));
      check("detect", 32'(den[i-1]), 32'(m_ol[i] != 6'h00));
    end
    // Zero low bound and a huge target pull the first start's integrator to exactly zero
    for (i = 1; i < 3; i++) begin
      xfer(1'b1, CODE_INTEGRATOR_BOUNDS, 2'(i), 24'h7FF000);
      xfer(1'b1, CODE_SWITCHING_PERIOD_CONTROL, 2'(i), 24'h700FFF);
    end
    clp_host_model_inst.idle();
    cs <= 2'h3;
    @(posedge core_clk_i);
    cs <= 2'h0;
    g = $urandom_range(3, 0);
    for (i = 1; i < 3; i++) begin
      xfer(1'b1, CODE_SWITCHING_PERIOD_CONTROL, 2'(i), {1'b0, 3'(g), 20'h0});
    end
    clp_host_model_inst.idle();
    // Gaps of 16k+1 edges give exactly k ticks whatever the prescaler phase
    acc = 0;
    for (i = 0; i < 4; i++) begin
      k = $urandom_range(12, 3);
      repeat (16 * k - ((i == 0) ? 3 : 1)) @(posedge core_clk_i);
      cs <= 2'h3;
      @(posedge core_clk_i);
      cs <= 2'h0;
      acc = acc + 32'(k >> g);
      @(negedge core_clk_i);
      check("period 0", 32'(mp[0]), 32'(k));
      check("period 1", 32'(mp[1]), 32'(k));
      @(posedge core_clk_i);
      @(negedge core_clk_i);
      check("threshold 0", 32'(thr[0]), acc);
      check("threshold 1", 32'(thr[1]), acc);
    end
    m_thr[1] = 16'(acc);
    m_thr[2] = 16'(acc);
    for (i = 1; i < 3; i++) begin
      xfer(1'b0, CODE_TURNOFF_THRESHOLD_OPEN_LOAD, 2'(i), 24'h0);
    end
    clp_host_model_inst.idle();
    repeat (5) @(posedge core_clk_i);
    check("queue", 32'(expq.size()), 32'h0);
    give_verdict();
  end
  initial begin
    #200000;
    err_count++;
    give_verdict();
  end
endmodule // clp_regs_tb
bind clp_regs clp_regs_assertions clp_regs_assertions_inst(.core_clk_i(core_clk_i),
  .reset_i(reset_i), .frame_valid_i(frame_valid_i), .frame_data_i(frame_data_i),
  .cycle_start_i(cycle_start_i), .reply_valid_o(reply_valid_o),
  .reply_data_o(reply_data_o), .turnoff_threshold_o(turnoff_threshold_o),
  .measured_period_o(measured_period_o), .open_load_thresh_o(open_load_thresh_o),
  .open_load_detect_en_o(open_load_detect_en_o));
